// [core/thr_pkg.sv]
// constants shared by the threshold and interval output logic
`default_nettype none
package thr_pkg;
  // register offsets
  localparam logic [7:0] OFS_CAP_FLAGS      = 8'h11;
  localparam logic [7:0] OFS_INTERVAL       = 8'h12;
  localparam logic [7:0] OFS_CH0_SENS_A     = 8'h40;
  localparam logic [7:0] OFS_CH1_SENS_A     = 8'h41;
  localparam logic [7:0] OFS_CAP_GLOBAL_B   = 8'h42;
  localparam logic [7:0] OFS_CH0_TUNING     = 8'h43;
  localparam logic [7:0] OFS_CH1_TUNING     = 8'h44;
  localparam logic [7:0] OFS_CAP_GLOBAL_D   = 8'h45;
  localparam logic [7:0] OFS_CH0_PROX_THR   = 8'h50;
  localparam logic [7:0] OFS_CH0_TOUCH_THR  = 8'h51;
  localparam logic [7:0] OFS_CH1_PROX_THR   = 8'h52;
  localparam logic [7:0] OFS_CH1_TOUCH_THR  = 8'h53;
  localparam logic [7:0] OFS_ROTATION_UI    = 8'h70;
  localparam logic [7:0] OFS_MAGNET_SENS    = 8'h71;
  localparam logic [7:0] OFS_MAGNET_TUNE_A  = 8'h72;
  localparam logic [7:0] OFS_MAGNET_TUNE_B  = 8'h73;
  localparam logic [7:0] OFS_DIR_RATIO      = 8'h78;
  localparam logic [7:0] OFS_SINE_PHASE     = 8'h79;
  localparam logic [7:0] OFS_COSINE_PHASE   = 8'h7A;
  localparam logic [7:0] OFS_FILTER_BETA    = 8'h7B;
  localparam logic [7:0] OFS_WHEEL_WAKE     = 8'h7C;
  localparam logic [7:0] OFS_INTERVAL_DIV   = 8'h7D;
  localparam logic [7:0] OFS_OFFSET_LOW     = 8'h7E;
  localparam logic [7:0] OFS_OFFSET_HIGH    = 8'h7F;
  // settings window: 0x40..0x7F share one storage array
  localparam logic [1:0] CFG_WINDOW_TOP     = 2'h1;
  localparam int         CFG_DEPTH          = 64;
  // field positions
  localparam int         BIT_CH0_PROX       = 0;
  localparam int         BIT_CH1_PROX       = 1;
  localparam int         BIT_CH0_TOUCH      = 4;
  localparam int         BIT_CH1_TOUCH      = 5;
  localparam int         BIT_DIR_INVERT     = 0;
  localparam logic [7:0] FLAGS_USED_MASK    = 8'h33;
  // reset values
  localparam logic [7:0] RST_DEFAULT        = 8'h00;
  localparam logic [7:0] RST_ROTATION_UI    = 8'h14;
  localparam logic [7:0] RST_INTERVAL_DIV   = 8'h03;
  // arithmetic constants
  localparam logic [9:0] FULL_TURN_DEG      = 10'h168;
  localparam int         TOUCH_FRAC_SHIFT   = 8;
  localparam logic [7:0] THR_FLOOR          = 8'h01;
  localparam logic [7:0] INTERVAL_MAX       = 8'hFF;

  // true for every settings offset that holds storage
  function automatic logic isCfgOffset(input logic [7:0] ofs);
    case (ofs)
      OFS_CH0_SENS_A, OFS_CH1_SENS_A, OFS_CAP_GLOBAL_B, OFS_CH0_TUNING,
      OFS_CH1_TUNING, OFS_CAP_GLOBAL_D, OFS_CH0_PROX_THR,
      OFS_CH0_TOUCH_THR, OFS_CH1_PROX_THR, OFS_CH1_TOUCH_THR,
      OFS_ROTATION_UI, OFS_MAGNET_SENS, OFS_MAGNET_TUNE_A,
      OFS_MAGNET_TUNE_B, OFS_DIR_RATIO, OFS_SINE_PHASE, OFS_COSINE_PHASE,
      OFS_FILTER_BETA, OFS_WHEEL_WAKE, OFS_INTERVAL_DIV, OFS_OFFSET_LOW,
      OFS_OFFSET_HIGH: isCfgOffset = 1'b1;
      default:         isCfgOffset = 1'b0;
    endcase
  endfunction : isCfgOffset
endpackage : thr_pkg
`default_nettype wire

// [core/two_wire_target.sv]
// two-wire bus target: pointer, auto-increment writes and reads
`default_nettype none
module two_wire_target #(
  parameter logic [6:0] BUS_ADDR = 7'h44
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // bus pins, sampled on sys_clk
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output var  logic       sdaOe,
  // register side
  output var  logic [7:0] rdAddr,
  input  wire logic [7:0] rdData,
  output var  logic [7:0] wrAddr,
  output var  logic [7:0] wrData,
  output var  logic       wrStrobe
);
  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} bus_state_e;

  logic       sclMeta_r, sclSync_r, sclPrev_r;
  logic       sdaMeta_r, sdaSync_r, sdaPrev_r;
  bus_state_e state_r;
  logic [7:0] shift_r;
  logic [3:0] bitCnt_r;
  logic       addrPhase_r, isRead_r, havePtr_r, mAck_r;
  logic [7:0] ptr_r;
  logic       sclRise, sclFall, startSeen, stopSeen;

  // two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    sclMeta_r <= sclIn;
    sclSync_r <= sclMeta_r;
    sclPrev_r <= sclSync_r;
    sdaMeta_r <= sdaIn;
    sdaSync_r <= sdaMeta_r;
    sdaPrev_r <= sdaSync_r;
  end

  assign sclRise   = sclSync_r & ~sclPrev_r;
  assign sclFall   = ~sclSync_r & sclPrev_r;
  assign startSeen = sclSync_r & sclPrev_r & sdaPrev_r & ~sdaSync_r;
  assign stopSeen  = sclSync_r & sclPrev_r & ~sdaPrev_r & sdaSync_r;
  assign rdAddr    = ptr_r;

  // byte engine; data changes only after a falling clock edge
  always_ff @(posedge sys_clk)
  begin
    wrStrobe <= 1'b0;
    if (reset)
    begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      bitCnt_r <= 4'h0;
      addrPhase_r <= 1'b0;
      isRead_r <= 1'b0;
      havePtr_r <= 1'b0;
      mAck_r <= 1'b0;
      ptr_r <= 8'h00;
      sdaOe <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
    end
    else if (startSeen)
    begin
      state_r <= ST_RX;
      bitCnt_r <= 4'h0;
      addrPhase_r <= 1'b1;
      havePtr_r <= 1'b0;
      sdaOe <= 1'b0;
    end
    else if (stopSeen)
    begin
      state_r <= ST_IDLE;
      sdaOe <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_RX:
        begin
          if (sclRise)
          begin
            shift_r <= {shift_r[6:0], sdaSync_r};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == 4'h8)
          begin
            state_r <= ST_ACK;
            sdaOe <= 1'b1;
            if (addrPhase_r)
            begin
              addrPhase_r <= 1'b0;
              isRead_r <= shift_r[0];
              if (shift_r[7:1] != BUS_ADDR)
              begin
                state_r <= ST_IDLE; // not ours: no acknowledge
                sdaOe <= 1'b0;
              end
            end
            else if (!havePtr_r)
            begin
              ptr_r <= shift_r;
              havePtr_r <= 1'b1;
            end
            else
            begin
              wrAddr <= ptr_r;
              wrData <= shift_r;
              wrStrobe <= 1'b1;
              ptr_r <= ptr_r + 8'h01;
            end
          end
        end
        ST_ACK:
        begin
          if (sclFall)
          begin
            bitCnt_r <= 4'h0;
            if (isRead_r)
            begin
              state_r <= ST_TX;
              shift_r <= rdData;
              sdaOe <= ~rdData[7];
            end
            else
            begin
              state_r <= ST_RX;
              sdaOe <= 1'b0;
            end
          end
        end
        ST_TX:
        begin
          if (sclFall)
          begin
            if (bitCnt_r == 4'h7)
            begin
              state_r <= ST_TXACK;
              sdaOe <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
            end
            else
            begin
              shift_r <= {shift_r[6:0], 1'b0};
              sdaOe <= ~shift_r[6];
              bitCnt_r <= bitCnt_r + 4'h1;
            end
          end
        end
        ST_TXACK:
        begin
          if (sclRise)
            mAck_r <= ~sdaSync_r;
          else if (sclFall)
          begin
            bitCnt_r <= 4'h0;
            if (mAck_r)
            begin
              state_r <= ST_TX;
              shift_r <= rdData;
              sdaOe <= ~rdData[7];
            end
            else
              state_r <= ST_IDLE; // master refused more data
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule : two_wire_target
`default_nettype wire

// [core/touch_hall_threshold_output.sv]
// capacitive threshold flags, hall differentials and interval output
// Functional notes
// - proximity threshold per channel, 1 to 255, lower means keener.
// - touch threshold is setting over 256 times long term average.
// - each capacitive channel has its own touch threshold register.
// - flag bit 5 tracks channel 1 touch, bit 4 channel 0 touch.
// - flag bit 1 tracks channel 1 proximity, bit 0 channel 0 proximity.
// - channels 2,4 positive, 3,5 negative; differences feed the angle.
// - channels 2,3 form the first plate, channels 4,5 the second.
// - current interval is an 8-bit value sized by the divider setting.
// - interval number ranges from zero to 360 over divider minus one, at most 255.
`default_nettype none
module touch_hall_threshold_output #(
  parameter logic [6:0] BUS_ADDR  = 7'h44,
  parameter int         CNT_W     = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // two-wire bus pins
  input  wire logic             sclIn,
  input  wire logic             sdaIn,
  output var  logic             sdaOut,
  output var  logic             sdaOe,
  // capacitive measurement results
  input  wire logic             measDone,
  input  wire logic [CNT_W-1:0] ch0Delta,
  input  wire logic [CNT_W-1:0] ch1Delta,
  input  wire logic [CNT_W-1:0] ch0LongTermAvg,
  input  wire logic [CNT_W-1:0] ch1LongTermAvg,
  // hall channel counts
  input  wire logic             hallValid,
  input  wire logic [CNT_W-1:0] hallCh2,
  input  wire logic [CNT_W-1:0] hallCh3,
  input  wire logic [CNT_W-1:0] hallCh4,
  input  wire logic [CNT_W-1:0] hallCh5,
  // filtered wheel angle in degrees
  input  wire logic             angleValid,
  input  wire logic [8:0]       angleDeg,
  // results
  output var  logic [7:0]       capFlags,
  output var  logic [7:0]       intervalNumber,
  output var  logic [CNT_W:0]   plate1Diff,
  output var  logic [CNT_W:0]   plate2Diff
);
  logic [7:0]         cfgMem [0:thr_pkg::CFG_DEPTH-1];
  logic [7:0]         rdAddr, rdData, wrAddr, wrData;
  logic               wrStrobe, busOe;
  logic [7:0]         flags_r, flags_nxt, interval_r;
  logic [7:0]         prox0, prox1, touch0, touch1;
  logic [CNT_W+7:0]   prod0, prod1;
  logic [CNT_W-1:0]   touchThr0, touchThr1;
  logic [7:0]         divider;
  logic [15:0]        wheelOffset, offsetMod;
  logic [9:0]         angleIn, dirAngle, sumRaw, sumWrap;
  logic [9:0]         idxRaw, idxMax;
  logic [7:0]         idxNext;
  logic               dirInvert;

  // settings array slot for a settings offset
  function automatic logic [5:0] slot(input logic [7:0] ofs);
    slot = ofs[5:0];
  endfunction : slot

  // bus engine; it only ever pulls the data line low
  two_wire_target #(
    .BUS_ADDR (BUS_ADDR)
  ) u_bus (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .sdaOe    (busOe),
    .rdAddr   (rdAddr),
    .rdData   (rdData),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .wrStrobe (wrStrobe)
  );

  // open-drain data pin: driven level is always low
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sdaOut <= 1'b0;
    else
      sdaOut <= 1'b0;
  end
  assign sdaOe = busOe;

  // settings storage; unlisted offsets in the window are not stored
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < thr_pkg::CFG_DEPTH; i++)
        cfgMem[i] <= thr_pkg::RST_DEFAULT;
      cfgMem[slot(thr_pkg::OFS_ROTATION_UI)] <= thr_pkg::RST_ROTATION_UI;
      cfgMem[slot(thr_pkg::OFS_INTERVAL_DIV)] <= thr_pkg::RST_INTERVAL_DIV;
    end
    else if (wrStrobe && thr_pkg::isCfgOffset(wrAddr))
      cfgMem[slot(wrAddr)] <= wrData;
  end

  // read mux; unmapped offsets answer zero
  always_comb
  begin
    rdData = 8'h00;
    if (rdAddr == thr_pkg::OFS_CAP_FLAGS)
      rdData = flags_r;
    else if (rdAddr == thr_pkg::OFS_INTERVAL)
      rdData = interval_r;
    else if (thr_pkg::isCfgOffset(rdAddr))
      rdData = cfgMem[slot(rdAddr)];
  end

  // a zero setting is outside 1..255, so it acts as the most sensitive
  always_comb
  begin
    prox0 = cfgMem[slot(thr_pkg::OFS_CH0_PROX_THR)];
    prox1 = cfgMem[slot(thr_pkg::OFS_CH1_PROX_THR)];
    touch0 = cfgMem[slot(thr_pkg::OFS_CH0_TOUCH_THR)];
    touch1 = cfgMem[slot(thr_pkg::OFS_CH1_TOUCH_THR)];
    if (prox0 == 8'h00)
      prox0 = thr_pkg::THR_FLOOR;
    if (prox1 == 8'h00)
      prox1 = thr_pkg::THR_FLOOR;
    if (touch0 == 8'h00)
      touch0 = thr_pkg::THR_FLOOR;
    if (touch1 == 8'h00)
      touch1 = thr_pkg::THR_FLOOR;
  end

  // touch level as a fraction x/256 of each channel's own average
  assign prod0 = touch0 * ch0LongTermAvg;
  assign prod1 = touch1 * ch1LongTermAvg;
  assign touchThr0 = prod0[CNT_W+7:thr_pkg::TOUCH_FRAC_SHIFT];
  assign touchThr1 = prod1[CNT_W+7:thr_pkg::TOUCH_FRAC_SHIFT];

  // next flag image; unnamed bits stay zero
  always_comb
  begin
    flags_nxt = 8'h00;
    flags_nxt[thr_pkg::BIT_CH0_PROX] = ch0Delta > CNT_W'(prox0);
    flags_nxt[thr_pkg::BIT_CH1_PROX] = ch1Delta > CNT_W'(prox1);
    flags_nxt[thr_pkg::BIT_CH0_TOUCH] = ch0Delta > touchThr0;
    flags_nxt[thr_pkg::BIT_CH1_TOUCH] = ch1Delta > touchThr1;
  end

  // flags change only at the end of a measurement, so a read never
  // sees a half-updated pair of bits
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      flags_r <= 8'h00;
    else if (measDone)
      flags_r <= flags_nxt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      capFlags <= 8'h00;
    else if (measDone)
      capFlags <= flags_nxt;
  end

  // plate differentials: positive minus negative channel
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      plate1Diff <= '0;
      plate2Diff <= '0;
    end
    else if (hallValid)
    begin
      plate1Diff <= {1'b0, hallCh2} - {1'b0, hallCh3};
      plate2Diff <= {1'b0, hallCh4} - {1'b0, hallCh5};
    end
  end

  // wheel angle with direction and offset applied
  assign dirInvert =
    cfgMem[slot(thr_pkg::OFS_DIR_RATIO)][thr_pkg::BIT_DIR_INVERT];
  assign wheelOffset = {cfgMem[slot(thr_pkg::OFS_OFFSET_HIGH)],
                        cfgMem[slot(thr_pkg::OFS_OFFSET_LOW)]};
  assign offsetMod = wheelOffset % {6'h00, thr_pkg::FULL_TURN_DEG};

  always_comb
  begin
    angleIn = {1'b0, angleDeg};
    if (angleIn >= thr_pkg::FULL_TURN_DEG)
      angleIn = angleIn - thr_pkg::FULL_TURN_DEG;
    dirAngle = angleIn;
    if (dirInvert && angleIn != 10'h000)
      dirAngle = thr_pkg::FULL_TURN_DEG - angleIn;
    sumRaw = dirAngle + offsetMod[9:0];
    sumWrap = sumRaw;
    if (sumRaw >= thr_pkg::FULL_TURN_DEG)
      sumWrap = sumRaw - thr_pkg::FULL_TURN_DEG;
  end

  // interval index; a zero divider is treated as one degree
  always_comb
  begin
    divider = cfgMem[slot(thr_pkg::OFS_INTERVAL_DIV)];
    if (divider == 8'h00)
      divider = thr_pkg::THR_FLOOR;
    idxRaw = sumWrap / {2'h0, divider};
    idxMax = (thr_pkg::FULL_TURN_DEG / {2'h0, divider}) - 10'h001;
    if (idxRaw > idxMax)
      idxRaw = idxMax;
    // only a divider of one can overflow eight bits; saturate rather than wrap
    if (idxRaw > {2'h0, thr_pkg::INTERVAL_MAX})
      idxNext = thr_pkg::INTERVAL_MAX;
    else
      idxNext = idxRaw[7:0];
  end

  // interval register: a new angle wins over a host write in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      interval_r <= 8'h00;
    else if (angleValid)
      interval_r <= idxNext;
    else if (wrStrobe && wrAddr == thr_pkg::OFS_INTERVAL)
      interval_r <= wrData;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      intervalNumber <= 8'h00;
    else if (angleValid)
      intervalNumber <= idxNext;
    else if (wrStrobe && wrAddr == thr_pkg::OFS_INTERVAL)
      intervalNumber <= wrData;
  end

  // checks
  property p_prox_ch0;
    @(posedge sys_clk) disable iff (reset)
    measDone |=> flags_r[0] == ($past(ch0Delta) > CNT_W'($past(prox0)));
  endproperty
  a_prox_ch0: assert property (p_prox_ch0)
    else $error("channel 0 proximity flag wrong");

  property p_prox_ch1;
    @(posedge sys_clk) disable iff (reset)
    measDone |=> flags_r[1] == ($past(ch1Delta) > CNT_W'($past(prox1)));
  endproperty
  a_prox_ch1: assert property (p_prox_ch1)
    else $error("channel 1 proximity flag wrong");

  property p_prox_floor;
    @(posedge sys_clk) disable iff (reset)
    (prox0 >= 8'h01) && (prox1 >= 8'h01);
  endproperty
  a_prox_floor: assert property (p_prox_floor)
    else $error("proximity threshold below one count");

  // product kept at full width before the shift, or large averages wrap
  property p_touch_ch1;
    @(posedge sys_clk) disable iff (reset)
    measDone |=> flags_r[5] ==
      ($past(ch1Delta) > CNT_W'(($past(touch1) *
       {8'h00, $past(ch1LongTermAvg)}) >> thr_pkg::TOUCH_FRAC_SHIFT));
  endproperty
  a_touch_ch1: assert property (p_touch_ch1)
    else $error("channel 1 touch flag wrong");

  // the output copy must match the register and the ch0 touch level
  property p_touch_ch0;
    @(posedge sys_clk) disable iff (reset)
    measDone |=> capFlags == flags_r && flags_r[4] ==
      ($past(ch0Delta) > CNT_W'(($past(touch0) *
       {8'h00, $past(ch0LongTermAvg)}) >> thr_pkg::TOUCH_FRAC_SHIFT));
  endproperty
  a_touch_ch0: assert property (p_touch_ch0)
    else $error("channel 0 touch flag wrong");

  property p_touch_separate;
    @(posedge sys_clk) disable iff (reset)
    (wrStrobe && wrAddr == thr_pkg::OFS_CH1_TOUCH_THR) |=> $stable(touch0);
  endproperty
  a_touch_separate: assert property (p_touch_separate)
    else $error("channel 1 threshold write changed channel 0");

  property p_flags_hold;
    @(posedge sys_clk) disable iff (reset)
    !measDone |=> $stable(flags_r) && (flags_r & 8'hCC) == 8'h00;
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags moved outside a measurement end");

  property p_plate_diff;
    @(posedge sys_clk) disable iff (reset)
    hallValid |=> plate1Diff == ({1'b0, $past(hallCh2)} - $past(hallCh3))
      && plate2Diff == ({1'b0, $past(hallCh4)} - $past(hallCh5));
  endproperty
  a_plate_diff: assert property (p_plate_diff)
    else $error("plate differential wrong");

  property p_interval_range;
    @(posedge sys_clk) disable iff (reset)
    angleValid && divider >= 8'h02 |=>
      {2'h0, interval_r} < (10'h168 / {2'h0, $past(divider)});
  endproperty
  a_interval_range: assert property (p_interval_range)
    else $error("interval number out of range");

  property p_interval_take;
    @(posedge sys_clk) disable iff (reset)
    angleValid |=> interval_r == $past(idxNext)
      && intervalNumber == $past(idxNext);
  endproperty
  a_interval_take: assert property (p_interval_take)
    else $error("interval register not updated from angle");

  // a host write lands only when no angle arrives in the same cycle
  property p_interval_write;
    @(posedge sys_clk) disable iff (reset)
    !angleValid && wrStrobe && wrAddr == thr_pkg::OFS_INTERVAL |=>
      interval_r == $past(wrData) && intervalNumber == $past(wrData);
  endproperty
  a_interval_write: assert property (p_interval_write)
    else $error("host write of the interval register lost");

  property p_interval_hold;
    @(posedge sys_clk) disable iff (reset)
    !angleValid && !(wrStrobe && wrAddr == thr_pkg::OFS_INTERVAL) |=>
      $stable(interval_r) && $stable(intervalNumber);
  endproperty
  a_interval_hold: assert property (p_interval_hold)
    else $error("interval register moved without a cause");

  property p_invert;
    @(posedge sys_clk) disable iff (reset)
    dirInvert && angleDeg != 9'h000 && angleDeg < 9'h168 |->
      dirAngle == 10'h168 - {1'b0, angleDeg};
  endproperty
  a_invert: assert property (p_invert)
    else $error("direction invert not applied");
endmodule : touch_hall_threshold_output
`default_nettype wire

// [sim/host_model.sv]
// host two-wire bus master model: open-drain data with pull-up
`default_nettype none
module host_model #(
  parameter logic [6:0] BUS_ADDR = 7'h44
) (
  // bus pins
  output var  logic scl,
  output var  logic sdaLow,
  input  wire logic sdaWire
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter of the 320 ns bus clock
  localparam int Q = 80;
  int nacks;

  // clock stands high and data released between frames
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
    nacks = 0;
  end

  // data moves only while the clock is low
  task automatic bitOut(input logic b);
    sdaLow = !b;
    #(Q);
    scl = 1'b1;
    #(2*Q);
    scl = 1'b0;
    #(Q);
  endtask : bitOut

  // sample midway through the high phase, after the target has settled
  task automatic bitIn(output logic b);
    sdaLow = 1'b0;
    #(Q);
    scl = 1'b1;
    #(Q);
    b = sdaWire;
    #(Q);
    scl = 1'b0;
    #(Q);
  endtask : bitIn

  // start or repeated start: data falls while the clock is high
  task automatic start();
    sdaLow = 1'b0;
    #(Q);
    scl = 1'b1;
    #(Q);
    sdaLow = 1'b1;
    #(Q);
    scl = 1'b0;
    #(Q);
  endtask : start

  // stop: data rises while the clock is high
  task automatic stop();
    sdaLow = 1'b1;
    #(Q);
    scl = 1'b1;
    #(Q);
    sdaLow = 1'b0;
    #(2*Q);
  endtask : stop

  // byte msb first, then the target acknowledge
  task automatic sendByte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitOut(v[i]);
    bitIn(a);
    if (a !== 1'b0)
      nacks++;
  endtask : sendByte

  // pointer then one data byte
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    start();
    sendByte({BUS_ADDR, 1'b0});
    sendByte(ofs);
    sendByte(v);
    stop();
  endtask : wr

  // pointer, repeated start, one byte read and refused
  task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
    start();
    sendByte({BUS_ADDR, 1'b0});
    sendByte(ofs);
    start();
    sendByte({BUS_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--)
      bitIn(v[i]);
    bitOut(1'b1);
    stop();
  endtask : rd
endmodule : host_model
`default_nettype wire

// [sim/touch_hall_threshold_output_bench.sv]
// self-checking bench for the threshold flag and interval block
`default_nettype none
module touch_hall_threshold_output_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and bus pins
  logic        sysClk;
  logic        reset;
  logic        sclPin;
  logic        hostLow;
  logic        sdaOut;
  logic        sdaOe;
  wire logic   sdaPin;
  // measurement inputs
  logic        measDone;
  logic        hallValid;
  logic        angleValid;
  logic [8:0]  angleDeg;
  logic [15:0] d0, d1, lta0, lta1, h2, h3, h4, h5;
  // results and bookkeeping
  logic [7:0]  capFlags;
  logic [7:0]  intervalNumber;
  logic [16:0] plate1Diff;
  logic [16:0] plate2Diff;
  logic [7:0]  d;
  int          failCount;
  int          samplesChecked;

  // pulled-up data line, low while either side pulls
  assign sdaPin = !(hostLow || (sdaOe && !sdaOut));

  host_model i_host_model (.scl(sclPin), .sdaLow(hostLow),
    .sdaWire(sdaPin));

  touch_hall_threshold_output i_touch_hall_threshold_output (
    .sys_clk(sysClk), .reset(reset), .sclIn(sclPin), .sdaIn(sdaPin),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .measDone(measDone),
    .ch0Delta(d0), .ch1Delta(d1), .ch0LongTermAvg(lta0),
    .ch1LongTermAvg(lta1), .hallValid(hallValid), .hallCh2(h2),
    .hallCh3(h3), .hallCh4(h4), .hallCh5(h5), .angleValid(angleValid),
    .angleDeg(angleDeg), .capFlags(capFlags),
    .intervalNumber(intervalNumber), .plate1Diff(plate1Diff),
    .plate2Diff(plate2Diff));

  // 25 MHz system clock
  initial
  begin
    sysClk = 1'b0;
    forever #20 sysClk = !sysClk;
  end

  // one comparison, counted
  task automatic check(input string n, input logic [16:0] seen, want);
    samplesChecked++;
    if (seen !== want)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", n, want, seen);
    end
  endtask : check

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // one measurement pulse, flags compared once it has landed
  task automatic measure(input logic [15:0] a, b, la, lb,
                         input logic [7:0] want);
    @(posedge sysClk);
    measDone <= 1'b1;
    {d0, d1, lta0, lta1} <= {a, b, la, lb};
    @(posedge sysClk);
    measDone <= 1'b0;
    @(posedge sysClk);
    #1;
    check("capFlags", {9'h0, capFlags}, {9'h0, want});
  endtask : measure

  // one filtered angle pulse and the interval it maps to
  task automatic turn(input logic [8:0] deg, input logic [7:0] want);
    @(posedge sysClk);
    angleValid <= 1'b1;
    angleDeg <= deg;
    @(posedge sysClk);
    angleValid <= 1'b0;
    @(posedge sysClk);
    #1;
    check("intervalNumber", {9'h0, intervalNumber}, {9'h0, want});
  endtask : turn

  // reset values, plus an unmapped hole reading zero
  task automatic scenReset();
    check("flagsRst", {9'h0, capFlags}, 17'h0);
    i_host_model.rd(8'h70, d);
    check("rotationUi", {9'h0, d}, 17'h00014);
    i_host_model.rd(8'h7D, d);
    check("divider", {9'h0, d}, 17'h00003);
    i_host_model.rd(8'h46, d);
    check("hole", {9'h0, d}, 17'h0);
    // tuning word with its target above its base, stored as written
    i_host_model.wr(8'h43, 8'h5A);
    i_host_model.rd(8'h43, d);
    check("tuning", {9'h0, d}, 17'h0005A);
  endtask : scenReset

  // touch levels: ch0 0x80*0x200>>8=0x100, ch1 0x20*0x400>>8=0x80
  task automatic scenFlags();
    i_host_model.wr(8'h50, 8'h10);
    i_host_model.wr(8'h51, 8'h80);
    i_host_model.wr(8'h52, 8'h20);
    i_host_model.wr(8'h53, 8'h20);
    // a delta equal to a level is not above it
    measure(16'h0010, 16'h0080, 16'h0200, 16'h0400, 8'h02);
    measure(16'h0101, 16'h0021, 16'h0200, 16'h0400, 8'h13);
    measure(16'h0011, 16'h0081, 16'h0200, 16'h0400, 8'h23);
    measure(16'hFFFF, 16'hFFFF, 16'h0100, 16'h0100, 8'h33);
    measure(16'h0011, 16'h0081, 16'h0200, 16'h0400, 8'h23);
    // flags are read only: the write must leave them alone
    i_host_model.wr(8'h11, 8'hFF);
    i_host_model.rd(8'h11, d);
    check("flagsRead", {9'h0, d}, 17'h00023);
  endtask : scenFlags

  // plate differences, one negative
  task automatic scenHall();
    @(posedge sysClk);
    hallValid <= 1'b1;
    {h2, h3, h4, h5} <= {16'h0100, 16'h0300, 16'h0500, 16'h0080};
    @(posedge sysClk);
    hallValid <= 1'b0;
    @(posedge sysClk);
    #1;
    check("plate1Diff", plate1Diff, 17'h1FE00);
    check("plate2Diff", plate2Diff, 17'h00480);
  endtask : scenHall

  // interval mapping at both ends of the range, and reversal
  task automatic scenInterval();
    i_host_model.wr(8'h7D, 8'h24);
    turn(9'h064, 8'h02);
    turn(9'h167, 8'h09);
    i_host_model.wr(8'h78, 8'h01);
    turn(9'h064, 8'h07);
    turn(9'h000, 8'h00);
    i_host_model.wr(8'h78, 8'h00);
    i_host_model.wr(8'h7D, 8'h0A);
    turn(9'h167, 8'h23);
    i_host_model.rd(8'h12, d);
    check("intervalRead", {9'h0, d}, 17'h00023);
    // host may overwrite the interval; the output copy follows
    i_host_model.wr(8'h12, 8'h05);
    check("intervalWr", {9'h0, intervalNumber}, 17'h00005);
    // an 18 degree offset wraps 359 round to 17, interval 1
    i_host_model.wr(8'h7E, 8'h12);
    turn(9'h167, 8'h01);
  endtask : scenInterval

  // bound on the whole run
  initial
  begin
    repeat (60000) @(posedge sysClk);
    failCount++;
    close_out();
  end

  // main sequence
  initial
  begin
    reset = 1'b1;
    {measDone, hallValid, angleValid} = 3'h0;
    {angleDeg, d0, d1, lta0, lta1} = '0;
    {h2, h3, h4, h5} = '0;
    failCount = 0;
    samplesChecked = 0;
    repeat (4) @(posedge sysClk);
    reset <= 1'b0;
    repeat (2) @(posedge sysClk);
    #1;
    scenReset();
    scenFlags();
    scenHall();
    scenInterval();
    check("nacks", 17'(i_host_model.nacks), 17'h0);
    close_out();
  end
endmodule : touch_hall_threshold_output_bench
`default_nettype wire
